/* rtl/scmc_pkg.sv */
// Purpose: Constants and types for the clock mode control block
// Assumes: One 100 MHz clock; oscillators arrive as pin levels
// Notes: Ready counts are in cycles of the oscillator being timed
package scmc_pkg;
    // Register addresses
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_STAT = 2'h1;
    localparam logic [1:0] ADDR_CLR = 2'h2;
    localparam logic [1:0] ADDR_IEN = 2'h3;
    // Field positions of clock_mode_control
    localparam int CKS_LSB = 5;
    localparam int QUICK_WAKE_ENABLE_BIT = 4;
    localparam int LTO_BIT = 3;
    localparam int HTO_BIT = 2;
    localparam int IDLE_ON_HALT_BIT = 1;
    localparam int FAST_CLOCK_SELECT_BIT = 0;
    // Reset values
    localparam logic [2:0] CKS_RST = 3'h0;
    localparam logic QUICK_WAKE_ENABLE_RST = 1'b0;
    localparam logic IDLE_ON_HALT_RST = 1'b1;
    localparam logic FAST_CLOCK_SELECT_RST = 1'b1;
    // Divider codes below this select the slow clock
    localparam logic [2:0] CKS_FIRST_DIV = 3'h2;
    // Configuration encodings
    localparam logic [1:0] FAST_HXT = 2'h0;
    localparam logic [1:0] FAST_ERC = 2'h1;
    localparam logic [1:0] FAST_INT_FAST_RC = 2'h2;
    localparam logic SLOW_LXT = 1'b0;
    localparam logic SLOW_INT_SLOW_RC = 1'b1;
    // Pin order of the oscillator inputs
    localparam int PIN_HXT = 0;
    localparam int PIN_ERC = 1;
    localparam int PIN_INT_FAST_RC = 2;
    localparam int PIN_LXT = 3;
    localparam int PIN_INT_SLOW_RC = 4;
    localparam int NPIN = 5;
    // Ready counts in oscillator cycles
    localparam logic [10:0] HXT_READY_CYC = 11'h400;
    localparam logic [10:0] RC_READY_CYC = 11'h010;
    localparam logic [10:0] LXT_READY_CYC = 11'h400;
    localparam logic [10:0] INT_SLOW_RC_READY_CYC = 11'h002;
    // Core clock source codes
    localparam logic [1:0] SRC_FAST = 2'h0;
    localparam logic [1:0] SRC_DIV = 2'h1;
    localparam logic [1:0] SRC_SLOW = 2'h2;
    localparam logic [1:0] SRC_SUB = 2'h3;
    // Event bits of status, clear and enable
    localparam int EV_HALT = 0;
    localparam int EV_WAKE = 1;
    localparam int EV_REFUSE = 2;
    localparam int EV_FRDY = 3;
    localparam int NEV = 4;
    // Operating modes
    typedef enum logic [4:0] {
        MODE_RUN = 5'h01,
        MODE_STOP_ALL = 5'h02,
        MODE_STOP_SUB = 5'h04,
        MODE_IDLE_OFF = 5'h08,
        MODE_IDLE_ON = 5'h10
    } scmc_mode_t;
    // Whole state of the block
    typedef struct packed {
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic [NPIN-1:0] sync3;
        logic fast_on;
        logic slow_on;
        logic [5:0] fdiv;
        logic [1:0] cur_src;
        scmc_mode_t mode;
        logic fast_wake;
        logic [10:0] fcnt;
        logic [10:0] scnt;
        logic high_osc_ready;
        logic low_osc_ready;
        logic [2:0] cks;
        logic quick_wake_enable;
        logic idle_on_halt;
        logic fast_clock_select;
        logic [NEV-1:0] sts;
        logic [NEV-1:0] ien;
        logic [7:0] rdata;
        logic irq;
        logic core_en;
        logic sub_en;
        logic tbc_en;
        logic wdt_en;
        logic wdt_dis;
        logic cpu_run;
        logic [1:0] q4;
    } scmc_state_t;
endpackage

/* rtl/scmc_top.sv */
// Purpose: Core clock selection and low-power mode control
// Assumes: Oscillators are pin levels sampled by i_clock
// Notes: Clock outputs are one-cycle enables, not real clocks
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module scmc_top
    import scmc_pkg::*;
(
    input wire logic i_clock, // 100 MHz clock
    input wire logic i_reset, // Synchronous reset, high
    input wire logic [1:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, next cycle
    input wire logic [NPIN-1:0] i_osc, // Oscillator pin levels
    input wire logic [1:0] i_cfg_fast_src, // Fast source option
    input wire logic i_cfg_slow_src, // Core slow source option
    input wire logic i_cfg_sub_src, // Substitute source option
    input wire logic i_cfg_tbc_src, // Timebase source option
    input wire logic i_cfg_wdt_from_sub, // Watchdog from substitute
    input wire logic i_wdt_enable, // Watchdog function on
    input wire logic i_keep_system_clock_in_idle, // Idle keeps clock
    input wire logic i_voltage_detect_enable, // Detector on
    input wire logic i_sub_clock_keep_enable, // Keep sub in stop
    input wire logic i_halt_req, // Halt pulse from core
    input wire logic i_wake_req, // Wake pulse
    output logic o_core_clk_en, // System clock enable
    output logic o_cpu_run, // Processor may execute
    output logic o_fast_osc_on, // Fast oscillator enable
    output logic o_slow_osc_on, // Slow oscillators enable
    output logic o_sub_clk_en, // Substitute clock enable
    output logic o_tbc_clk_en, // Timebase clock enable
    output logic o_wdt_clk_en, // Watchdog clock enable
    output logic o_wdt_disable, // Watchdog forced off
    output logic [4:0] o_mode, // One-hot operating mode
    output logic o_irq // Interrupt, high level
);
    scmc_state_t state_r; // Registered state
    scmc_state_t state_nxt; // Next state
    logic [NPIN-1:0] edge_w; // Oscillator rising edges
    logic fast_tick; // Fast oscillator edge
    logic slow_tick; // Core slow source edge
    logic sub_tick; // Substitute source edge
    logic tbc_tick; // Timebase source edge
    logic div_tick; // Divided fast clock edge
    logic [5:0] div_mask; // Divider terminal mask
    logic [1:0] req_src; // Wanted core source
    logic req_tick; // Edge of wanted source
    logic core_tick; // Edge of current source
    logic sys_on; // System clock allowed
    logic sub_on; // Substitute clock allowed
    logic stop_sub_ok; // Stop may keep substitute
    logic [10:0] ftarget; // Fast ready count
    logic [10:0] starget; // Slow ready count
    logic [NEV-1:0] ev; // Events this cycle
    logic [NEV-1:0] clr; // Clear bits this cycle

    // Decode source edges, divider and core selection
    always_comb
    begin
        // Second and third stages form the edge; first stage feeds the second alone
        edge_w = state_r.sync2 & ~state_r.sync3;
        unique case (i_cfg_fast_src)
            FAST_HXT: fast_tick = edge_w[PIN_HXT];
            FAST_ERC: fast_tick = edge_w[PIN_ERC];
            default: fast_tick = edge_w[PIN_INT_FAST_RC];
        endcase
        // Stopped oscillator gives no edges
        fast_tick = fast_tick & state_r.fast_on;
        slow_tick = state_r.slow_on &
            (i_cfg_slow_src ? edge_w[PIN_INT_SLOW_RC] : edge_w[PIN_LXT]);
        sub_tick = state_r.slow_on &
            (i_cfg_sub_src ? edge_w[PIN_INT_SLOW_RC] : edge_w[PIN_LXT]);
        tbc_tick = state_r.slow_on &
            (i_cfg_tbc_src ? edge_w[PIN_INT_SLOW_RC] : edge_w[PIN_LXT]);
        // Code 010 is /64 down to 111 as /2
        unique case (state_r.cks)
            3'h2: div_mask = 6'h3f;
            3'h3: div_mask = 6'h1f;
            3'h4: div_mask = 6'h0f;
            3'h5: div_mask = 6'h07;
            3'h6: div_mask = 6'h03;
            default: div_mask = 6'h01;
        endcase
        div_tick = fast_tick && ((state_r.fdiv & div_mask) == div_mask);
        // Quick wake overrides; then fast, slow, or divided
        if (state_r.fast_wake)
            req_src = SRC_SUB;
        else if (state_r.fast_clock_select)
            req_src = SRC_FAST;
        else if (state_r.cks < CKS_FIRST_DIV)
            req_src = SRC_SLOW;
        else
            req_src = SRC_DIV;
        unique case (req_src)
            SRC_FAST: req_tick = fast_tick;
            SRC_DIV: req_tick = div_tick;
            SRC_SLOW: req_tick = slow_tick;
            default: req_tick = sub_tick;
        endcase
        unique case (state_r.cur_src)
            SRC_FAST: core_tick = fast_tick;
            SRC_DIV: core_tick = div_tick;
            SRC_SLOW: core_tick = slow_tick;
            default: core_tick = sub_tick;
        endcase
        sys_on = (state_r.mode == MODE_RUN) ||
            (state_r.mode == MODE_IDLE_ON);
        core_tick = core_tick & sys_on;
        sub_on = (state_r.mode != MODE_STOP_ALL);
        stop_sub_ok = i_sub_clock_keep_enable ||
            (i_wdt_enable && i_cfg_wdt_from_sub);
        ftarget = (i_cfg_fast_src == FAST_HXT) ?
            HXT_READY_CYC : RC_READY_CYC;
        starget = (i_cfg_slow_src == SLOW_INT_SLOW_RC) ?
            INT_SLOW_RC_READY_CYC : LXT_READY_CYC;
        clr = '0;
        if (i_wr && (i_addr == ADDR_CLR))
            clr = i_wdata[NEV-1:0];
    end

    // Next state: modes, oscillators, ready flags, registers
    always_comb
    begin
        state_nxt = state_r;
        ev = '0;
        state_nxt.sync1 = i_osc;
        state_nxt.sync2 = state_r.sync1;
        state_nxt.sync3 = state_r.sync2;
        state_nxt.fdiv = 6'(state_r.fdiv + 6'(fast_tick));
        // Change source only on the new source's own edge
        if ((req_src != state_r.cur_src) && req_tick)
            state_nxt.cur_src = req_src;
        // Halt controls are sampled with the request
        unique case (state_r.mode)
            MODE_RUN:
            begin
                if (i_halt_req && !state_r.idle_on_halt)
                begin
                    if (stop_sub_ok)
                        state_nxt.mode = MODE_STOP_SUB;
                    else if (i_voltage_detect_enable)
                        ev[EV_REFUSE] = 1'b1;
                    else
                        state_nxt.mode = MODE_STOP_ALL;
                    ev[EV_HALT] = stop_sub_ok || !i_voltage_detect_enable;
                end
                else if (i_halt_req)
                begin
                    // Idle keeps the clock only when asked
                    state_nxt.mode = i_keep_system_clock_in_idle ?
                        MODE_IDLE_ON : MODE_IDLE_OFF;
                    ev[EV_HALT] = 1'b1;
                end
            end
            default:
            begin
                if (i_wake_req)
                begin
                    state_nxt.mode = MODE_RUN;
                    ev[EV_WAKE] = 1'b1;
                    // Only modes that keep substitute running help
                    if (((state_r.mode == MODE_STOP_SUB) ||
                        (state_r.mode == MODE_IDLE_OFF)) &&
                        state_r.quick_wake_enable && (i_cfg_fast_src == FAST_HXT))
                        state_nxt.fast_wake = 1'b1;
                end
            end
        endcase
        if (state_r.fast_wake && state_r.high_osc_ready)
            state_nxt.fast_wake = 1'b0;
        // Fast oscillator off in slow mode and deep modes
        state_nxt.fast_on = ((state_nxt.mode == MODE_RUN) ||
            (state_nxt.mode == MODE_IDLE_ON)) &&
            (state_r.fast_clock_select || (state_r.cks >= CKS_FIRST_DIV) ||
            state_nxt.fast_wake);
        state_nxt.slow_on = (state_nxt.mode != MODE_STOP_ALL);
        // Fast ready counts oscillator edges after restart
        if (!state_r.fast_on || (state_r.mode == MODE_STOP_ALL) ||
            (state_r.mode == MODE_STOP_SUB) ||
            (state_r.mode == MODE_IDLE_OFF))
            state_nxt.fcnt = '0;
        else if (fast_tick && (state_r.fcnt < ftarget))
            state_nxt.fcnt = 11'(state_r.fcnt + 11'h001);
        state_nxt.high_osc_ready = (state_nxt.fcnt == ftarget);
        // Slow ready drops one cycle into either stop mode and stays low
        if (!state_r.slow_on || (state_r.mode == MODE_STOP_ALL) ||
            (state_r.mode == MODE_STOP_SUB))
            state_nxt.scnt = '0;
        else if (slow_tick && (state_r.scnt < starget))
            state_nxt.scnt = 11'(state_r.scnt + 11'h001);
        state_nxt.low_osc_ready = (state_nxt.scnt == starget);
        ev[EV_FRDY] = state_nxt.high_osc_ready && !state_r.high_osc_ready;
        // Clock enables, registered so outputs come from flops
        state_nxt.core_en = core_tick;
        state_nxt.cpu_run = (state_nxt.mode == MODE_RUN);
        state_nxt.sub_en = sub_tick && sub_on;
        state_nxt.tbc_en = tbc_tick && (state_r.mode != MODE_STOP_ALL) &&
            (state_r.mode != MODE_STOP_SUB);
        if (core_tick)
            state_nxt.q4 = 2'(state_r.q4 + 2'h1);
        // Core/4 dies with the core clock in idle-off
        state_nxt.wdt_en = i_cfg_wdt_from_sub ? (sub_tick && sub_on) :
            (core_tick && (state_r.q4 == 2'h3));
        state_nxt.wdt_dis = (state_nxt.mode == MODE_STOP_ALL);
        // Register writes; ready flags are read-only
        if (i_wr && (i_addr == ADDR_CTRL))
        begin
            state_nxt.cks = i_wdata[CKS_LSB+2:CKS_LSB];
            state_nxt.quick_wake_enable = i_wdata[QUICK_WAKE_ENABLE_BIT];
            state_nxt.idle_on_halt = i_wdata[IDLE_ON_HALT_BIT];
            state_nxt.fast_clock_select = i_wdata[FAST_CLOCK_SELECT_BIT];
        end
        if (i_wr && (i_addr == ADDR_IEN))
            state_nxt.ien = i_wdata[NEV-1:0];
        // Set wins over clear in the same cycle
        state_nxt.sts = (state_r.sts & ~clr) | ev;
        state_nxt.irq = |(state_nxt.sts & state_nxt.ien);
        // Read data valid only in the cycle after the strobe
        state_nxt.rdata = 8'h00;
        if (i_rd)
        begin
            unique case (i_addr)
                ADDR_CTRL: state_nxt.rdata = {state_r.cks, state_r.quick_wake_enable,
                    state_r.low_osc_ready, state_r.high_osc_ready, state_r.idle_on_halt,
                    state_r.fast_clock_select};
                ADDR_STAT: state_nxt.rdata = {4'h0, state_r.sts};
                ADDR_IEN: state_nxt.rdata = {4'h0, state_r.ien};
                default: state_nxt.rdata = 8'h00;
            endcase
        end
        // Reset values
        if (i_reset)
        begin
            state_nxt = '0;
            state_nxt.mode = MODE_RUN;
            state_nxt.cks = CKS_RST;
            state_nxt.quick_wake_enable = QUICK_WAKE_ENABLE_RST;
            state_nxt.idle_on_halt = IDLE_ON_HALT_RST;
            state_nxt.fast_clock_select = FAST_CLOCK_SELECT_RST;
            state_nxt.fast_on = 1'b1;
            state_nxt.slow_on = 1'b1;
            state_nxt.cur_src = SRC_FAST;
            state_nxt.cpu_run = 1'b1;
        end
    end

    // State register
    always_ff @(posedge i_clock)
    begin
        state_r <= state_nxt;
    end

    // Outputs straight from state flops
    assign o_rdata = state_r.rdata;
    assign o_core_clk_en = state_r.core_en;
    assign o_cpu_run = state_r.cpu_run;
    assign o_fast_osc_on = state_r.fast_on;
    assign o_slow_osc_on = state_r.slow_on;
    assign o_sub_clk_en = state_r.sub_en;
    assign o_tbc_clk_en = state_r.tbc_en;
    assign o_wdt_clk_en = state_r.wdt_en;
    assign o_wdt_disable = state_r.wdt_dis;
    assign o_mode = state_r.mode;
    assign o_irq = state_r.irq;

    // Checks on mode entry and clocks
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    chk_fast_stops_slow: assert property (
        (state_r.mode == MODE_RUN) && !state_r.fast_clock_select &&
        (state_r.cks < CKS_FIRST_DIV) && !state_r.fast_wake
        |=> !o_fast_osc_on)
        else $error("fast oscillator still on in slow mode");
    chk_halt_stop_all: assert property (
        (state_r.mode == MODE_RUN) && i_halt_req && !state_r.idle_on_halt &&
        !stop_sub_ok && !i_voltage_detect_enable
        |=> (o_mode == MODE_STOP_ALL) && o_wdt_disable && !o_cpu_run)
        else $error("halt did not enter stop-all");
    chk_voltage_block: assert property (
        (state_r.mode == MODE_RUN) && i_halt_req && !state_r.idle_on_halt &&
        !stop_sub_ok && i_voltage_detect_enable
        |=> (o_mode == MODE_RUN) && state_r.sts[EV_REFUSE])
        else $error("stop-all entered with detector on");
    chk_halt_idle_off: assert property (
        (state_r.mode == MODE_RUN) && i_halt_req && state_r.idle_on_halt &&
        !i_keep_system_clock_in_idle
        |=> (o_mode == MODE_IDLE_OFF) && !o_cpu_run && !o_fast_osc_on)
        else $error("idle-off entry wrong");
    chk_halt_idle_on: assert property (
        (state_r.mode == MODE_RUN) && i_halt_req && state_r.idle_on_halt &&
        i_keep_system_clock_in_idle
        |=> (o_mode == MODE_IDLE_ON) && !o_cpu_run)
        else $error("idle-on entry wrong");
    chk_stop_ready_low: assert property (
        (state_r.mode == MODE_STOP_ALL) [*2]
        |-> !state_r.high_osc_ready && !state_r.low_osc_ready && !o_sub_clk_en && !o_wdt_clk_en)
        else $error("ready flag or clock active in stop-all");
    chk_wdt_idle_off: assert property (
        ((state_r.mode == MODE_IDLE_OFF) && !i_cfg_wdt_from_sub) [*3]
        |-> !o_wdt_clk_en && !o_core_clk_en)
        else $error("core/4 watchdog clock running in idle-off");
    chk_quick_wake: assert property (
        $rose(state_r.fast_wake)
        |-> $past(state_r.quick_wake_enable) && (i_cfg_fast_src == FAST_HXT))
        else $error("quick wake without enable or crystal");
    chk_fast_ready: assert property (
        $rose(state_r.high_osc_ready) |-> (state_r.fcnt == ftarget))
        else $error("fast ready at wrong count");

    cov_stop_all: cover property (
        $rose(state_r.mode == MODE_STOP_ALL));
    cov_idle_on: cover property (
        $rose(state_r.mode == MODE_IDLE_ON));
    cov_quick_wake: cover property (
        $rose(state_r.fast_wake) ##[1:1000] $fell(state_r.fast_wake));
endmodule
`default_nettype wire

/* tb/scmc_osc_model.sv */
// Purpose: Oscillator pins seen by the clock mode block
// Assumes: Enables come from the block under test
// Notes: Fast pins toggle every 2 cycles, slow pins every 8
`timescale 1ns/1ps
`default_nettype none
module scmc_osc_model
    import scmc_pkg::*;
(
    input wire logic i_clock, // Bench clock
    input wire logic i_fast_on, // Fast oscillator enable
    input wire logic i_slow_on, // Slow oscillator enable
    output logic [NPIN-1:0] o_osc // Pin levels
);
    logic [3:0] fph = 4'h0; // Fast phase count
    logic [3:0] sph = 4'h0; // Slow phase count
    logic fast = 1'b0; // Fast wave level
    logic slow = 1'b0; // Slow wave level
    // A stopped oscillator freezes its pin, so no edges reach the block
    always @(posedge i_clock)
    begin
        if (i_fast_on)
        begin
            fph <= (fph == 4'h1) ? 4'h0 : fph + 4'h1;
            if (fph == 4'h1)
                fast <= ~fast;
        end
        if (i_slow_on) // Slow stops only in deep stop
        begin
            sph <= (sph == 4'h7) ? 4'h0 : sph + 4'h1;
            if (sph == 4'h7)
                slow <= ~slow;
        end
    end
    // Every source pin present; configuration picks among them
    assign o_osc = {slow, slow, fast, fast, fast};
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the clock mode block
// Assumes: Fast source int_fast_rc, slow sources int_slow_rc
// Notes: Pulse rates are checked with one count of phase slack
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_top
    import scmc_pkg::*;
;
    logic clk = 1'b0; // Bench clock
    logic rst = 1'b1; // Reset, high
    logic [1:0] addr = 2'h0; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic wr = 1'b0; // Write strobe
    logic rd = 1'b0; // Read strobe
    logic halt = 1'b0; // Halt pulse
    logic wake = 1'b0; // Wake pulse
    logic keep = 1'b0; // Keep clock in idle
    logic vdet = 1'b0; // Voltage detector on
    logic keep_sub = 1'b0; // Keep substitute in stop
    logic [1:0] cfg_fast = FAST_INT_FAST_RC; // Fixed fast option
    logic cfg_slow = SLOW_INT_SLOW_RC; // Fixed slow options
    logic wdt_sub = 1'b0; // Watchdog clock from substitute
    wire logic [7:0] rdata; // Read data
    wire logic [NPIN-1:0] osc; // Oscillator pins
    wire logic core_en, cpu_run, fast_on, slow_on; // Clock outputs
    wire logic sub_en, tbc_en, wdt_en, wdt_dis, irq; // Peripheral outputs
    wire logic [4:0] mode; // One-hot mode
    int bad_count = 0; // Mismatches
    int total_checks = 0; // Comparisons
    int cyc = 0; // Run length
    int n_core = 0, n_sub = 0, n_tbc = 0, n_wdt = 0; // Pulse tallies
    logic [7:0] d; // Read result
    int c, s, t, w, e; // Window counts and expectation
    scmc_osc_model scmc_osc_model_inst (.i_clock(clk), .i_fast_on(fast_on),
        .i_slow_on(slow_on), .o_osc(osc));
    scmc_top scmc_top_inst (.i_clock(clk), .i_reset(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_osc(osc),
        .i_cfg_fast_src(cfg_fast), .i_cfg_slow_src(cfg_slow),
        .i_cfg_sub_src(cfg_slow), .i_cfg_tbc_src(cfg_slow),
        .i_cfg_wdt_from_sub(wdt_sub), .i_wdt_enable(1'b1),
        .i_keep_system_clock_in_idle(keep), .i_voltage_detect_enable(vdet),
        .i_sub_clock_keep_enable(keep_sub), .i_halt_req(halt),
        .i_wake_req(wake), .o_core_clk_en(core_en), .o_cpu_run(cpu_run),
        .o_fast_osc_on(fast_on), .o_slow_osc_on(slow_on),
        .o_sub_clk_en(sub_en), .o_tbc_clk_en(tbc_en), .o_wdt_clk_en(wdt_en),
        .o_wdt_disable(wdt_dis), .o_mode(mode), .o_irq(irq));
    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Pulse tallies and hang guard; a hang ends as a failure
    always @(posedge clk)
    begin
        n_core += int'(core_en);
        n_sub += int'(sub_en);
        n_tbc += int'(tbc_en);
        n_wdt += int'(wdt_en);
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            wrap_up();
        end
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One-cycle register write
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // Read; data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Halt or wake pulse; outputs settle on the same edge that takes it
    task automatic req(input bit is_wake);
        @(posedge clk);
        if (is_wake)
            wake <= 1'b1;
        else
            halt <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        halt <= 1'b0;
        #1;
    endtask
    // Pulses of each clock enable over a window
    task automatic tally(input int n);
        c = n_core;
        s = n_sub;
        t = n_tbc;
        w = n_wdt;
        repeat (n) @(posedge clk);
        c = n_core - c;
        s = n_sub - s;
        t = n_tbc - t;
        w = n_wdt - w;
    endtask
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ADDR_CTRL, d);
        `CHK("ctrl_reset", 8'h03, d)
        repeat (300) @(posedge clk);
        wr_reg(ADDR_CTRL, 8'h1f);
        rd_reg(ADDR_CTRL, d);
        `CHK("ctrl_ready", 8'h1f, d)
        // Every divider code, then fast select; fast edges 256 per 1024
        for (int k = 0; k < 9; k++)
        begin
            wr_reg(ADDR_CTRL, (k == 8) ? 8'h03 : {k[2:0], 5'h02});
            repeat (300) @(posedge clk);
            e = (k == 8) ? 256 : (k < 2) ? 64 : (256 >> (8 - k));
            tally(1024);
            `CHK("core_rate", (c >= e - 1 && c <= e + 1), 1'b1)
            if (k < 2)
            begin
                `CHK("fast_off", 1'b0, fast_on)
                rd_reg(ADDR_CTRL, d);
                `CHK("ctrl_slow", {k[2:0], 5'h0a}, d)
            end
        end
        wr_reg(ADDR_IEN, 8'h01);
        keep <= 1'b1;
        req(1'b0);
        `CHK("mode_idle_on", 5'h10, mode)
        `CHK("cpu_stop", 1'b0, cpu_run)
        `CHK("irq_halt", 1'b1, irq)
        tally(200);
        `CHK("idle_on_clk", (c > 0 && w > 0 && t > 0), 1'b1)
        req(1'b1);
        `CHK("mode_run", 5'h01, mode)
        rd_reg(ADDR_STAT, d);
        `CHK("status", 8'h0b, d)
        wr_reg(ADDR_CLR, 8'h0f);
        rd_reg(ADDR_CLR, d);
        `CHK("clear_read", 8'h00, d)
        `CHK("irq_clear", 1'b0, irq)
        keep <= 1'b0;
        req(1'b0);
        `CHK("mode_idle_off", 5'h08, mode)
        `CHK("sys_osc_off", 1'b0, fast_on)
        tally(200);
        `CHK("wdt_off", (w == 0 && s > 0 && c == 0), 1'b1)
        rd_reg(ADDR_CTRL, d);
        `CHK("hto_idle", 8'h0b, d)
        wr_reg(ADDR_IEN, 8'h00);
        `CHK("irq_mask", 1'b0, irq)
        req(1'b1);
        repeat (300) @(posedge clk);
        wr_reg(ADDR_CLR, 8'h0f);
        wr_reg(ADDR_CTRL, 8'h01);
        vdet <= 1'b1;
        req(1'b0);
        `CHK("refuse_mode", 5'h01, mode)
        rd_reg(ADDR_STAT, d);
        `CHK("refuse_flag", 8'h04, d)
        vdet <= 1'b0;
        req(1'b0);
        `CHK("mode_stop_all", 5'h02, mode)
        `CHK("stop_all_out", 3'h4, {wdt_dis, fast_on, slow_on})
        tally(200);
        `CHK("stop_all_clk", (s == 0 && w == 0 && t == 0), 1'b1)
        rd_reg(ADDR_CTRL, d);
        `CHK("ready_stop", 8'h01, d)
        req(1'b1);
        repeat (300) @(posedge clk);
        keep_sub <= 1'b1;
        req(1'b0);
        `CHK("mode_stop_sub", 5'h04, mode)
        tally(200);
        `CHK("sub_kept", (s > 0 && c == 0), 1'b1)
        req(1'b1);
        `CHK("mode_back", 5'h01, mode)
        // Idle-off with the watchdog on the substitute clock keeps it
        wr_reg(ADDR_CTRL, 8'h03);
        keep_sub <= 1'b0;
        wdt_sub <= 1'b1;
        req(1'b0);
        `CHK("mode_idle_off_sub", 5'h08, mode)
        tally(200);
        `CHK("wdt_sub_on", (w > 0 && c == 0), 1'b1)
        req(1'b1);
        `CHK("mode_back_sub", 5'h01, mode)
        wrap_up();
    end
endmodule
`default_nettype wire
